// [hdl/tmz_timer.sv]
`timescale 1ns/1ps
`include "tmz_defines.svh"
`default_nettype none
module tmz_timer #(
  parameter int ADDR_W = 16
)
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // axi4-lite register bus
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // count sources
  input  wire logic              count_pin_input_i,
  input  wire logic              fast_internal_osc_i,
  input  wire logic              slow_internal_osc_i,
  input  wire logic              medium_internal_osc_i,
  input  wire logic              secondary_osc_i,
  input  wire logic              logic_cell_one_output_i,
  // power and interrupt
  input  wire logic              sleep_i,
  input  wire logic              timer_irq_enable_i,
  input  wire logic              timer_irq_clear_i,
  output logic                   timer_output_signal_o,
  output logic                   timer_irq_flag_o,
  output logic                   irq_req_o,
  output logic                   wake_o
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  tmz_pkg::tmz_byte_t low_ff, hi_reg_ff, hi_live_ff, buf_ff, ctl0_ff, ctl1_ff;
  tmz_pkg::tmz_byte_t nxt_low, nxt_hi_reg, nxt_hi_live, nxt_buf, nxt_ctl0, nxt_ctl1;
  tmz_pkg::tmz_pre_t  pre_ff, nxt_pre, pre_limit;
  logic [3:0]         post_ff, nxt_post;
  logic               out_ff, nxt_out;
  logic               flag_ff, nxt_flag;
  logic               wr_en, rd_en;
  tmz_pkg::tmz_sel_t  wr_sel, rd_sel;
  tmz_pkg::tmz_byte_t wr_data, rd_data;
  logic               en, wide, async_mode, src_raw, src_rise, src_tick;
  logic               wr_low, wr_high, wr_ctl, cnt_en, ptick, evt, post_wrap, match;
  logic [15:0]        pre_span;
  logic [15:0]        wide_next;

  // ----------------------------------------------------------------------
  // bus slave and source edge detect
  // ----------------------------------------------------------------------
  tmz_axil_slave #(.ADDR_W(ADDR_W)) u_bus
  (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en_o       (wr_en),
    .wr_sel_o      (wr_sel),
    .wr_data_o     (wr_data),
    .rd_en_o       (rd_en),
    .rd_sel_o      (rd_sel),
    .rd_data_i     (rd_data)
  );

  assign en         = ctl0_ff[`TMZ_C0_EN];
  assign wide       = ctl0_ff[`TMZ_C0_WIDE];
  assign async_mode = ctl1_ff[`TMZ_C1_ASYNC];

  always_comb
  begin
    case (ctl1_ff[`TMZ_C1_CS])
      `TMZ_CS_PIN:     src_raw = count_pin_input_i;
      `TMZ_CS_PIN_INV: src_raw = ~count_pin_input_i;
      `TMZ_CS_FAST:    src_raw = fast_internal_osc_i;
      `TMZ_CS_SLOW:    src_raw = slow_internal_osc_i;
      `TMZ_CS_MEDIUM:  src_raw = medium_internal_osc_i;
      `TMZ_CS_SECOND:  src_raw = secondary_osc_i;
      `TMZ_CS_LOGIC:   src_raw = logic_cell_one_output_i;
      default:         src_raw = 1'b0;
    endcase
  end

  tmz_src_edge u_edge
  (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .src_i   (src_raw),
    .async_i (async_mode),
    .rise_o  (src_rise)
  );

  // the instruction clock ticks every cycle; sleep only stops synchronized counting
  assign src_tick = (ctl1_ff[`TMZ_C1_CS] == `TMZ_CS_INSTR) ? 1'b1 : src_rise;
  assign cnt_en = en & src_tick & ~(sleep_i & ~async_mode);

  // ----------------------------------------------------------------------
  // register access decode
  // ----------------------------------------------------------------------
  assign wr_low  = wr_en & (wr_sel == `TMZ_SEL_LOW);
  assign wr_high = wr_en & (wr_sel == `TMZ_SEL_HIGH);
  assign wr_ctl  = wr_en & ((wr_sel == `TMZ_SEL_CTL0) | (wr_sel == `TMZ_SEL_CTL1));

  always_comb
  begin
    case (rd_sel)
      `TMZ_SEL_LOW:  rd_data = low_ff;
      `TMZ_SEL_HIGH: rd_data = hi_reg_ff;
      `TMZ_SEL_CTL0: rd_data = {ctl0_ff[`TMZ_C0_EN], 1'b0, timer_output_signal_o,
                                ctl0_ff[`TMZ_C0_WIDE], ctl0_ff[`TMZ_C0_POST]};
      default:       rd_data = ctl1_ff;
    endcase
  end

  // ----------------------------------------------------------------------
  // prescaler, counter and postscaler
  // ----------------------------------------------------------------------
  assign pre_span  = 16'h0001 << ctl1_ff[`TMZ_C1_CKPS];
  assign pre_limit = tmz_pkg::tmz_pre_t'(pre_span - 16'h0001);
  assign ptick     = cnt_en & (pre_ff == pre_limit);
  assign match     = (low_ff == buf_ff);
  assign wide_next = {hi_live_ff, low_ff} + 16'h0001;
  assign evt       = ptick & (wide ? (wide_next == 16'h0000) : match);
  assign post_wrap = (post_ff == ctl0_ff[`TMZ_C0_POST]);

  always_comb
  begin
    nxt_ctl0    = ctl0_ff;
    nxt_ctl1    = ctl1_ff;
    nxt_low     = low_ff;
    nxt_hi_reg  = hi_reg_ff;
    nxt_hi_live = hi_live_ff;
    nxt_buf     = buf_ff;
    nxt_pre     = pre_ff;
    nxt_post    = post_ff;
    nxt_out     = out_ff;
    if (cnt_en)
      nxt_pre = (pre_ff == pre_limit) ? '0 : pre_ff + 15'h0001;
    if (ptick)
    begin
      if (wide)
      begin
        nxt_low     = wide_next[7:0];
        nxt_hi_live = wide_next[15:8];
      end
      else if (match)
      begin
        nxt_low = `TMZ_RST_BYTE;
        nxt_buf = hi_reg_ff;
      end
      else
        nxt_low = low_ff + 8'h01;
    end
    if (evt)
    begin
      nxt_post = post_wrap ? 4'h0 : post_ff + 4'h1;
      if (post_wrap)
        nxt_out = ~out_ff;
    end
    // in 16-bit mode a read of the low byte snapshots the live high byte
    if (rd_en & (rd_sel == `TMZ_SEL_LOW) & wide)
      nxt_hi_reg = hi_live_ff;
    if (wr_high)
      nxt_hi_reg = wr_data;
    if (wr_low)
    begin
      nxt_low = wr_data;
      if (wide)
        nxt_hi_live = hi_reg_ff;
    end
    if (wr_en & (wr_sel == `TMZ_SEL_CTL0))
      nxt_ctl0 = wr_data;
    if (wr_en & (wr_sel == `TMZ_SEL_CTL1))
      nxt_ctl1 = wr_data;
    if (wr_low | wr_ctl)
    begin
      nxt_pre  = '0;
      nxt_post = 4'h0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctl0_ff    <= `TMZ_RST_BYTE;
      ctl1_ff    <= `TMZ_RST_BYTE;
      low_ff     <= `TMZ_RST_BYTE;
      hi_reg_ff  <= `TMZ_RST_BYTE;
      hi_live_ff <= `TMZ_RST_BYTE;
      buf_ff     <= `TMZ_RST_BYTE;
      pre_ff     <= '0;
      post_ff    <= 4'h0;
      out_ff     <= 1'b0;
    end
    else
    begin
      ctl0_ff    <= nxt_ctl0;
      ctl1_ff    <= nxt_ctl1;
      low_ff     <= nxt_low;
      hi_reg_ff  <= nxt_hi_reg;
      hi_live_ff <= nxt_hi_live;
      buf_ff     <= nxt_buf;
      pre_ff     <= nxt_pre;
      post_ff    <= nxt_post;
      out_ff     <= nxt_out;
    end
  end

  // ----------------------------------------------------------------------
  // output and interrupt flag
  // ----------------------------------------------------------------------
  // ctl0 bit 5 reads back this output; a software write to it is stored in ctl0_ff but never used
  assign timer_output_signal_o = (~wide & (hi_reg_ff == 8'h00)) | out_ff;

  always_comb
  begin
    // a toggle in the same cycle as a clear wins, so no event is lost
    nxt_flag = (evt & post_wrap) | (flag_ff & ~timer_irq_clear_i);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      flag_ff <= 1'b0;
    else
      flag_ff <= nxt_flag;
  end

  assign timer_irq_flag_o = flag_ff;
  assign irq_req_o = flag_ff & timer_irq_enable_i;
  assign wake_o    = irq_req_o & sleep_i & async_mode;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_prescale_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_low | wr_ctl) |=> (pre_ff == '0) && (post_ff == 4'h0))
    else $error("prescaler or postscaler not cleared by write");

  a_zero_period_high: assert property (@(posedge clk_i) disable iff (rst_i)
    (!wide && hi_reg_ff == 8'h00) |-> timer_output_signal_o)
    else $error("output not high with zero period");

  a_flag_on_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
    (out_ff != $past(out_ff)) |-> flag_ff)
    else $error("flag not set when output toggled");

  a_post_ratio: assert property (@(posedge clk_i) disable iff (rst_i)
    (evt && !post_wrap && !(wr_low | wr_ctl)) |=> $stable(out_ff))
    else $error("output toggled before ratio reached");

  a_disabled_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (!en && !wr_en) |=> $stable(low_ff) && $stable(pre_ff) && !$rose(flag_ff))
    else $error("disabled timer changed state");

  a_sync_sleep_stop: assert property (@(posedge clk_i) disable iff (rst_i)
    (sleep_i && !async_mode && !wr_en) |=> $stable(low_ff) && $stable(hi_live_ff))
    else $error("synchronized timer counted in sleep");

  a_match_restart: assert property (@(posedge clk_i) disable iff (rst_i)
    (ptick && !wide && match && !wr_en) |=> (low_ff == 8'h00) && (buf_ff == $past(hi_reg_ff)))
    else $error("match did not restart count");

  a_wide_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
    (ptick && wide && low_ff == `TMZ_BYTE_MAX && hi_live_ff == `TMZ_BYTE_MAX && !wr_en)
      |=> (low_ff == 8'h00) && (hi_live_ff == 8'h00))
    else $error("16-bit counter did not wrap");

  a_low_write_high: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_low && wide) |=> hi_live_ff == $past(hi_reg_ff))
    else $error("high byte not transferred on low write");
endmodule
`default_nettype wire

// [hdl/tmz_defines.svh]
`ifndef TMZ_DEFINES_SVH
`define TMZ_DEFINES_SVH

// ----------------------------------------------------------------------
// register indexes (byte address is four times the index)
// ----------------------------------------------------------------------
`define TMZ_IDX_LOW    14'h059c
`define TMZ_IDX_HIGH   14'h059d
`define TMZ_IDX_CTL0   14'h059e
`define TMZ_IDX_CTL1   14'h059f
`define TMZ_SEL_LOW    2'h0
`define TMZ_SEL_HIGH   2'h1
`define TMZ_SEL_CTL0   2'h2
`define TMZ_SEL_CTL1   2'h3

// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define TMZ_C0_EN      7
`define TMZ_C0_OUT     5
`define TMZ_C0_WIDE    4
`define TMZ_C0_POST    3:0
`define TMZ_C1_CS      7:5
`define TMZ_C1_ASYNC   4
`define TMZ_C1_CKPS    3:0
`define TMZ_RST_BYTE   8'h00
`define TMZ_BYTE_MAX   8'hff

// ----------------------------------------------------------------------
// count source codes and bus answers
// ----------------------------------------------------------------------
`define TMZ_CS_PIN     3'h0
`define TMZ_CS_PIN_INV 3'h1
`define TMZ_CS_INSTR   3'h2
`define TMZ_CS_FAST    3'h3
`define TMZ_CS_SLOW    3'h4
`define TMZ_CS_MEDIUM  3'h5
`define TMZ_CS_SECOND  3'h6
`define TMZ_CS_LOGIC   3'h7
`define TMZ_RESP_OKAY  2'h0
`define TMZ_RESP_SLVERR 2'h2

`endif

// [hdl/tmz_pkg.sv]
`default_nettype none
package tmz_pkg;
  typedef logic [7:0]  tmz_byte_t;
  typedef logic [1:0]  tmz_sel_t;
  typedef logic [14:0] tmz_pre_t;
endpackage
`default_nettype wire

// [hdl/tmz_src_edge.sv]
`timescale 1ns/1ps
`default_nettype none
module tmz_src_edge
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // selected source and mode
  input  wire logic src_i,
  input  wire logic async_i,
  // one-cycle pulse per rising edge
  output logic      rise_o
);
  logic sync1_ff;
  logic sync2_ff;
  logic sync3_ff;
  logic raw_ff;
  logic nxt_sync1;
  logic nxt_sync2;
  logic nxt_sync3;
  logic nxt_raw;

  always_comb
  begin
    nxt_sync1 = src_i;
    nxt_sync2 = sync1_ff;
    nxt_sync3 = sync2_ff;
    nxt_raw   = src_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      sync3_ff <= 1'b0;
      raw_ff   <= 1'b0;
    end
    else
    begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      sync3_ff <= nxt_sync3;
      raw_ff   <= nxt_raw;
    end
  end

  // async path skips the synchroniser, trading metastability margin for latency
  assign rise_o = async_i ? (src_i & ~raw_ff) : (sync2_ff & ~sync3_ff);
endmodule
`default_nettype wire

// [hdl/tmz_axil_slave.sv]
`timescale 1ns/1ps
`include "tmz_defines.svh"
`default_nettype none
module tmz_axil_slave #(
  parameter int ADDR_W = 16
)
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // write address and data
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // read address and data
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // register side
  output logic                   wr_en_o,
  output tmz_pkg::tmz_sel_t      wr_sel_o,
  output tmz_pkg::tmz_byte_t     wr_data_o,
  output logic                   rd_en_o,
  output tmz_pkg::tmz_sel_t      rd_sel_o,
  input  wire tmz_pkg::tmz_byte_t rd_data_i
);
  logic              aw_ff, w_ff, b_ff, r_ff;
  logic              nxt_aw, nxt_w, nxt_b, nxt_r;
  logic [ADDR_W-1:0] awa_ff, nxt_awa;
  logic [7:0]        wd_ff, nxt_wd;
  logic              ws_ff, nxt_ws;
  logic [1:0]        bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [31:0]       rd_ff, nxt_rd;
  logic              w_hit, r_hit;

  assign s_axi_awready = ~aw_ff;
  assign s_axi_wready  = ~w_ff;
  assign s_axi_arready = ~r_ff;
  assign s_axi_bvalid  = b_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_rvalid  = r_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = rd_ff;
  assign w_hit = awa_ff[ADDR_W-1:4] == `TMZ_IDX_LOW >> 2;
  assign r_hit = s_axi_araddr[ADDR_W-1:4] == `TMZ_IDX_LOW >> 2;
  assign wr_sel_o  = awa_ff[3:2];
  assign rd_sel_o  = s_axi_araddr[3:2];
  assign wr_data_o = wd_ff;

  always_comb
  begin
    nxt_aw = aw_ff | s_axi_awvalid;
    nxt_awa = (s_axi_awvalid & ~aw_ff) ? s_axi_awaddr : awa_ff;
    nxt_w  = w_ff | s_axi_wvalid;
    nxt_wd = (s_axi_wvalid & ~w_ff) ? s_axi_wdata[7:0] : wd_ff;
    nxt_ws = (s_axi_wvalid & ~w_ff) ? s_axi_wstrb[0] : ws_ff;
    nxt_b = b_ff & ~s_axi_bready;
    nxt_bresp = bresp_ff;
    wr_en_o = 1'b0;
    // both halves held and no answer pending: commit and answer next cycle
    if (aw_ff & w_ff & ~b_ff)
    begin
      wr_en_o = w_hit & ws_ff;
      nxt_b = 1'b1;
      nxt_aw = 1'b0;
      nxt_w = 1'b0;
      nxt_bresp = w_hit ? `TMZ_RESP_OKAY : `TMZ_RESP_SLVERR;
    end
    rd_en_o = s_axi_arvalid & ~r_ff & r_hit;
    nxt_r = r_ff & ~s_axi_rready;
    nxt_rd = rd_ff;
    nxt_rresp = rresp_ff;
    if (s_axi_arvalid & ~r_ff)
    begin
      nxt_r = 1'b1;
      nxt_rd = r_hit ? {24'h000000, rd_data_i} : 32'h00000000;
      nxt_rresp = r_hit ? `TMZ_RESP_OKAY : `TMZ_RESP_SLVERR;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      b_ff <= 1'b0;
      r_ff <= 1'b0;
      awa_ff <= '0;
      wd_ff <= 8'h00;
      ws_ff <= 1'b0;
      bresp_ff <= 2'h0;
      rresp_ff <= 2'h0;
      rd_ff <= 32'h00000000;
    end
    else
    begin
      aw_ff <= nxt_aw;
      w_ff <= nxt_w;
      b_ff <= nxt_b;
      r_ff <= nxt_r;
      awa_ff <= nxt_awa;
      wd_ff <= nxt_wd;
      ws_ff <= nxt_ws;
      bresp_ff <= nxt_bresp;
      rresp_ff <= nxt_rresp;
      rd_ff <= nxt_rd;
    end
  end
endmodule
`default_nettype wire

// [bench/tmz_tb.sv]
`timescale 1ns/1ps
`include "tmz_defines.svh"
`default_nettype none
module tb;
  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  localparam logic [15:0] A_LOW  = {`TMZ_IDX_LOW, 2'h0};
  localparam logic [15:0] A_HIGH = {`TMZ_IDX_HIGH, 2'h0};
  localparam logic [15:0] A_CTL0 = {`TMZ_IDX_CTL0, 2'h0};
  localparam logic [15:0] A_CTL1 = {`TMZ_IDX_CTL1, 2'h0};
  logic        clk_i;
  logic        rst_i;
  logic [15:0] awaddr;
  logic [15:0] araddr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [1:0]  bresp;
  logic [1:0]  rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic        pin, fast, slow, med, sec, lc;
  logic        sleep, irq_en, irq_clr, out, flag, irq_req, wake;
  logic [7:0]  src_en;
  logic [3:0]  tog;
  logic [31:0] va;
  logic [31:0] vb;
  logic [1:0]  rsp;
  int          g;
  int          n_fail;
  int          checks_done;
  int          cp[4] = '{3, 5, 1, 2};
  int          cn[4] = '{0, 2, 1, 15};
  int          ck[4] = '{0, 0, 1, 0};

  tmz_timer uut (
    .clk_i(clk_i), .rst_i(rst_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .count_pin_input_i(pin), .fast_internal_osc_i(fast), .slow_internal_osc_i(slow),
    .medium_internal_osc_i(med), .secondary_osc_i(sec), .logic_cell_one_output_i(lc),
    .sleep_i(sleep), .timer_irq_enable_i(irq_en), .timer_irq_clear_i(irq_clr),
    .timer_output_signal_o(out), .timer_irq_flag_o(flag), .irq_req_o(irq_req), .wake_o(wake)
  );

  // ----------------------------------------------------------------------
  // clock and count sources
  // ----------------------------------------------------------------------
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // only the sources enabled in src_en toggle, so a wrong select shows up
  always @(posedge clk_i)
  begin
    tog  <= rst_i ? 4'h0 : tog + 4'h1;
    pin  <= tog[1] & (src_en[0] | src_en[1]);
    fast <= tog[1] & src_en[3];
    slow <= tog[1] & src_en[4];
    med  <= tog[1] & src_en[5];
    sec  <= tog[1] & src_en[6];
    lc   <= tog[1] & src_en[7];
  end

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    if (n_fail == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic axw(input logic [15:0] a, input logic [7:0] d, output logic [1:0] r);
    @(posedge clk_i);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    axw(a, d, rsp);
    chk({30'h0, rsp}, {30'h0, `TMZ_RESP_OKAY});
  endtask

  task automatic rdchk(input logic [15:0] a, input logic [31:0] exp);
    axr(a, va, rsp);
    chk(va, exp);
    chk({30'h0, rsp}, {30'h0, `TMZ_RESP_OKAY});
  endtask

  // cycles until the output level changes; sampled before the edge lands
  task automatic edge_gap(output int gap);
    logic p;
    p   = out;
    gap = 0;
    do
    begin
      @(posedge clk_i);
      gap++;
    end
    while (out === p && gap < 5000);
  endtask

  task automatic clr_pulse;
    irq_clr <= 1'b1;
    @(posedge clk_i);
    irq_clr <= 1'b0;
    @(posedge clk_i);
  endtask

  // ----------------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (30000) @(posedge clk_i);
    n_fail++;
    finish_test;
  end

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial
  begin
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    {sleep, irq_en, irq_clr, src_en} = '0;
    n_fail = 0;
    checks_done = 0;
    rst_i = 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(A_LOW, 32'h00);
    rdchk(A_HIGH, 32'h00);
    rdchk(A_CTL0, 32'h20);
    rdchk(A_CTL1, 32'h00);
    axr(16'h1680, va, rsp);
    chk(va, 32'h00000000);
    chk({30'h0, rsp}, {30'h0, `TMZ_RESP_SLVERR});
    // an unmapped write must answer an error and leave the count alone
    axw(16'h1680, 8'hff, rsp);
    chk({30'h0, rsp}, {30'h0, `TMZ_RESP_SLVERR});
    rdchk(A_LOW, 32'h00);
    wr(A_CTL0, 8'h6f);
    rdchk(A_CTL0, 32'h2f);
    // period, postscale and prescale combinations
    for (int i = 0; i < 4; i++)
    begin
      wr(A_HIGH, 8'(cp[i]));
      wr(A_CTL1, 8'h40 | 8'(ck[i]));
      wr(A_CTL0, 8'h80 | 8'(cn[i]));
      edge_gap(g);
      edge_gap(g);
      chk(g, ((cp[i] + 1) * (cn[i] + 1)) << ck[i]);
      edge_gap(g);
      chk(g, ((cp[i] + 1) * (cn[i] + 1)) << ck[i]);
    end
    wr(A_HIGH, 8'h00);
    repeat (30) @(posedge clk_i);
    repeat (20)
    begin
      @(posedge clk_i);
      chk(out, 1'b1);
    end
    rdchk(A_CTL0, 32'haf);
    // flag, clear and request
    wr(A_HIGH, 8'h03);
    wr(A_CTL0, 8'h80);
    irq_en <= 1'b1;
    edge_gap(g);
    clr_pulse;
    chk(flag, 1'b0);
    chk(irq_req, 1'b0);
    edge_gap(g);
    @(posedge clk_i);
    chk(flag, 1'b1);
    chk(irq_req, 1'b1);
    irq_en <= 1'b0;
    @(posedge clk_i);
    @(posedge clk_i);
    chk(irq_req, 1'b0);
    // sleep: synchronized input halts, unsynchronized keeps going
    sleep <= 1'b1;
    repeat (6) @(posedge clk_i);
    axr(A_LOW, va, rsp);
    repeat (20) @(posedge clk_i);
    axr(A_LOW, vb, rsp);
    chk(vb, va);
    wr(A_CTL1, 8'h50);
    clr_pulse;
    irq_en <= 1'b1;
    g = 0;
    while (wake !== 1'b1 && g < 40)
    begin
      @(posedge clk_i);
      g++;
    end
    chk(wake, 1'b1);
    {sleep, irq_en} <= 2'b00;
    // disabled module holds state and raises no flag
    wr(A_CTL0, 8'h00);
    clr_pulse;
    axr(A_LOW, va, rsp);
    repeat (30) @(posedge clk_i);
    axr(A_LOW, vb, rsp);
    chk(vb, va);
    chk(flag, 1'b0);
    // every count source, with only the wrong ones toggling and then the right one
    wr(A_HIGH, 8'hff);
    wr(A_CTL0, 8'h80);
    for (int c = 0; c < 8; c++)
    begin
      wr(A_CTL1, {3'(c), 5'h00});
      for (int ok = 0; ok < 2; ok++)
      begin
        src_en <= (c < 2) ? (ok ? 8'h03 : 8'hfc) : (ok ? 8'h01 << c : ~(8'h01 << c));
        repeat (8) @(posedge clk_i);
        axr(A_LOW, va, rsp);
        repeat (30) @(posedge clk_i);
        axr(A_LOW, vb, rsp);
        chk(vb != va, (ok == 1) || (c == 2));
      end
    end
    // sixteen-bit buffered access and rollover
    wr(A_CTL1, 8'h40);
    wr(A_CTL0, 8'h10);
    wr(A_HIGH, 8'hff);
    wr(A_LOW, 8'hf0);
    rdchk(A_LOW, 32'hf0);
    rdchk(A_HIGH, 32'hff);
    wr(A_CTL0, 8'h90);
    edge_gap(g);
    chk(g < 40, 1'b1);
    axr(A_LOW, va, rsp);
    rdchk(A_HIGH, 32'h00);
    finish_test;
  end
endmodule
`default_nettype wire
